// ===== common/cache_burst_pkg.sv
package cache_burst_pkg;
  // ---------------------------------------------
  // Configuration space and control bits
  // ---------------------------------------------
  localparam logic [7:0] CLS_OFFSET      = 8'h0C;
  localparam logic [7:0] CLS_RESET       = 8'h00;
  localparam int         WIE_BIT         = 0;
  localparam int         PCI_MWI_EN_BIT  = 4;
  localparam int         READ_LINE_BIT   = 3;
  localparam int         BURST_HI_BIT    = 2;
  localparam int         BURST_FIELD_LSB = 6;
  // ---------------------------------------------
  // Sizes, as log2 of dwords
  // ---------------------------------------------
  localparam logic [2:0] LINE_LOG_MIN    = 3'h1;
  localparam logic [2:0] LINE_LOG_MAX    = 3'h7;
  localparam logic [2:0] QUAD_LOG        = 3'h2;
  localparam logic [2:0] BURST_HI_ADD    = 3'h4;
  // ---------------------------------------------
  // Bus commands
  // ---------------------------------------------
  localparam logic [3:0] CMD_MEM_READ    = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE   = 4'h7;
  localparam logic [3:0] CMD_READ_LINE   = 4'hE;
  localparam logic [3:0] CMD_WRITE_INV   = 4'hF;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [7:0]  len;
    logic [3:0]  be;
  } burst_s;

  typedef enum logic [1:0] {ST_IDLE, ST_PLAN, ST_REQ, ST_XFER} burst_state_e;
endpackage

// ===== hdl/cache_burst_ctrl.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Write data staging FIFO
// ---------------------------------------------
module cache_burst_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
  logic             full, empty, ready_reg, ready_next;

  // Depth must be a power of two for the wrap bit to work
  assign full        = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty       = (wr_reg == rd_reg);
  assign in_ready_o  = ready_reg;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_reg[AW-1:0]];

  always_comb begin
    wr_next = wr_reg + ((in_valid_i && !full) ? 1'b1 : 1'b0);
    rd_next = rd_reg + ((out_ready_i && !empty) ? 1'b1 : 1'b0);
    // Ready from the next pointers, so it leaves a flip-flop yet tracks full exactly
    ready_next = (wr_next[AW] == rd_next[AW]) || (wr_next[AW-1:0] != rd_next[AW-1:0]);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      ready_reg <= 1'b1;
    end else begin
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      ready_reg <= ready_next;
    end
    if (in_valid_i && !full) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module cache_burst_ctrl (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Configuration space access
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [7:0]  cfg_wdata_i,
  output logic      [7:0]  cfg_rdata_o,
  // Mode bits
  input  wire logic [7:0]  dma_mode_reg_i,
  input  wire logic [7:0]  chip_test_reg_three_i,
  input  wire logic [7:0]  chip_test_reg_five_i,
  input  wire logic        cache_mode_enable_i,
  input  wire logic [15:0] pci_command_i,
  // Job
  input  wire logic        job_start_i,
  input  wire logic [31:0] job_addr_i,
  input  wire logic [31:0] job_src_addr_i,
  input  wire logic [23:0] job_bytes_i,
  input  wire logic        job_write_i,
  input  wire logic        job_opfetch_i,
  input  wire logic        job_mem_move_i,
  input  wire logic [15:0] dma_fifo_bytes_i,
  output logic             job_busy_o,
  output logic             job_done_o,
  // Write data
  input  wire logic        wdata_valid_i,
  input  wire logic [31:0] wdata_i,
  output logic             wdata_ready_o,
  // Bus master side
  output logic             bus_req_o,
  input  wire logic        bus_gnt_i,
  input  wire logic        target_ack_i,
  input  wire logic        target_stop_i,
  input  wire logic        lat_expired_i,
  output logic             burst_start_o,
  output logic      [3:0]  burst_cmd_o,
  output logic      [31:0] burst_addr_o,
  output logic      [7:0]  burst_len_o,
  output logic      [3:0]  byte_en_o,
  output logic      [31:0] pci_wdata_o
);
  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  logic [3:0] pin_raw, sync1_reg, sync2_reg;
  assign pin_raw = {lat_expired_i, target_stop_i, target_ack_i, bus_gnt_i};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge sys_clk_i) begin
      sync1_reg[g] <= rst_i ? 1'b0 : pin_raw[g];
      sync2_reg[g] <= rst_i ? 1'b0 : sync1_reg[g];
    end
  end
  logic gnt_s, ack_s, stop_s, lat_s;
  assign {lat_s, stop_s, ack_s, gnt_s} = sync2_reg;

  // ---------------------------------------------
  // Line size selection
  // ---------------------------------------------
  logic [7:0]  cls_reg, cls_next;
  logic [2:0]  cls_log, max_log, eff_log;
  logic        cls_legal, cache_act, misalign_reg, misalign_next;
  logic [31:0] line_mask, max_dw, line_dw;

  always_comb begin
    cls_log = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (cls_reg[i]) cls_log = 3'(i);
    end
    max_log = 3'(dma_mode_reg_i[cache_burst_pkg::BURST_FIELD_LSB +: 2])
            + cache_burst_pkg::LINE_LOG_MIN;
    if (chip_test_reg_five_i[cache_burst_pkg::BURST_HI_BIT]) begin
      max_log = (max_log > 3'h3) ? cache_burst_pkg::LINE_LOG_MAX
              : max_log + cache_burst_pkg::BURST_HI_ADD;
    end
    eff_log = (cls_log < max_log) ? cls_log : max_log;
    cls_legal = (cls_reg == (8'h01 << cls_log)) && (cls_log >= cache_burst_pkg::LINE_LOG_MIN)
              && (cls_log <= max_log);
    cls_next = (cfg_wr_i && cfg_addr_i == cache_burst_pkg::CLS_OFFSET) ? cfg_wdata_i : cls_reg;
  end

  // Shift amount widened: a 3-bit sum would wrap for 64 and 128 dword lines
  assign line_mask = (32'h1 << ({1'b0, eff_log} + 4'h2)) - 32'h1;
  assign line_dw   = 32'h1 << eff_log;
  assign max_dw    = 32'h1 << max_log;
  assign cache_act = cache_mode_enable_i && (cls_log >= cache_burst_pkg::LINE_LOG_MIN)
                   && !misalign_reg;

  // ---------------------------------------------
  // Burst planning
  // ---------------------------------------------
  cache_burst_pkg::burst_state_e state_reg, state_next;
  cache_burst_pkg::burst_s       burst_reg, burst_next, plan;
  logic [31:0] addr_reg, addr_next, dw_left, lim, mwi_len;
  logic [23:0] rem_reg, rem_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [2:0]  k, pb;
  logic        line_al, mwi_ok, lat_reg, lat_next, end_lat;
  logic        job_write_reg, job_opfetch_reg, fifo_valid, fifo_pop;

  assign line_al = (addr_reg & line_mask) == 32'h0;
  assign dw_left = {10'h0, rem_reg[23:2]};
  assign mwi_ok  = chip_test_reg_three_i[cache_burst_pkg::WIE_BIT] && cache_mode_enable_i
                 && pci_command_i[cache_burst_pkg::PCI_MWI_EN_BIT] && cache_act
                 && cls_legal && line_al && {16'h0, dma_fifo_bytes_i} > line_mask
                 && {8'h0, rem_reg} > line_mask;

  always_comb begin
    plan      = '0;
    plan.addr = addr_reg;
    k         = cache_burst_pkg::QUAD_LOG;
    lim       = 32'h0;
    mwi_len   = 32'h0;
    // Two-dword lines are line aligned off quad boundaries and keep bursting
    if (addr_reg[1:0] != 2'h0 || rem_reg < 24'h4
        || (cache_act && addr_reg[3:0] != 4'h0 && !line_al)) begin
      plan.len = 8'h01;
      for (int j = 0; j < 4; j++) begin
        plan.be[j] = (j >= addr_reg[1:0]) && (24'(j) < 24'(addr_reg[1:0]) + rem_reg);
      end
    end else begin
      if (!cache_act || line_al) begin
        k = cache_act ? eff_log : max_log;
      end else begin
        for (int i = 3; i < 8; i++) begin
          if (3'(i) < eff_log && (addr_reg & ((32'h1 << (i + 2)) - 32'h1)) == 32'h0) k = 3'(i);
        end
      end
      lim      = (32'h1 << k);
      plan.len = 8'((lim < dw_left) ? lim : dw_left);
      plan.be  = 4'hF;
    end
    if (job_write_reg) begin
      plan.cmd = cache_burst_pkg::CMD_MEM_WRITE;
      if (mwi_ok) begin
        lim      = (max_dw < dw_left) ? max_dw : dw_left;
        mwi_len  = lim & ~(line_dw - 32'h1);
        plan.cmd = cache_burst_pkg::CMD_WRITE_INV;
        plan.len = 8'(mwi_len);
      end
    end else if (!job_opfetch_reg && dma_mode_reg_i[cache_burst_pkg::READ_LINE_BIT]
                 && (!cache_mode_enable_i || (cls_legal && cache_act && line_al
                 && {8'h0, rem_reg} >= (max_dw << 2)))) begin
      plan.cmd = cache_burst_pkg::CMD_READ_LINE;
    end else begin
      plan.cmd = cache_burst_pkg::CMD_MEM_READ;
    end
  end

  // ---------------------------------------------
  // Transfer sequencing
  // ---------------------------------------------
  logic bus_req_next, start_next, done_next, busy_next;
  logic bus_req_reg, start_reg, done_reg, busy_reg;
  logic [31:0] fifo_data, wdata_reg;

  assign pb      = 3'h4 - {1'b0, addr_reg[1:0]};
  assign end_lat = (burst_reg.cmd == cache_burst_pkg::CMD_WRITE_INV)
                 ? (((addr_reg + 32'h4) & line_mask) == 32'h0) : 1'b1;
  assign fifo_pop = (state_reg == cache_burst_pkg::ST_XFER) && ack_s && job_write_reg;

  always_comb begin
    state_next    = state_reg;
    burst_next    = burst_reg;
    addr_next     = addr_reg;
    rem_next      = rem_reg;
    cnt_next      = cnt_reg;
    lat_next      = lat_reg;
    misalign_next = misalign_reg;
    start_next    = 1'b0;
    done_next     = 1'b0;
    case (state_reg)
      cache_burst_pkg::ST_IDLE: begin
        if (job_start_i) begin
          addr_next     = job_addr_i;
          rem_next      = job_bytes_i;
          misalign_next = job_mem_move_i && ((job_addr_i & line_mask) != (job_src_addr_i & line_mask));
          state_next    = (job_bytes_i == 24'h0) ? cache_burst_pkg::ST_IDLE : cache_burst_pkg::ST_PLAN;
          done_next     = (job_bytes_i == 24'h0);
        end
      end
      cache_burst_pkg::ST_PLAN: begin
        burst_next = plan;
        cnt_next   = plan.len;
        lat_next   = 1'b0;
        state_next = cache_burst_pkg::ST_REQ;
      end
      cache_burst_pkg::ST_REQ: begin
        // Write bursts wait for at least one staged word; the FIFO is not checked again during the burst
        if (gnt_s && (fifo_valid || !job_write_reg)) begin
          state_next = cache_burst_pkg::ST_XFER;
          start_next = 1'b1;
        end
      end
      cache_burst_pkg::ST_XFER: begin
        if (lat_s) lat_next = 1'b1;
        if (ack_s) begin
          addr_next = addr_reg + ((burst_reg.len == 8'h01) ? 32'(pb) : 32'h4);
          rem_next  = rem_reg - ((burst_reg.len == 8'h01 && 24'(pb) > rem_reg) ? rem_reg
                    : (burst_reg.len == 8'h01) ? 24'(pb) : 24'h4);
          cnt_next  = cnt_reg - 8'h01;
        end
        if ((ack_s && (cnt_reg == 8'h01 || ((lat_reg || lat_s) && end_lat))) || stop_s) begin
          state_next = (rem_next == 24'h0) ? cache_burst_pkg::ST_IDLE : cache_burst_pkg::ST_PLAN;
          done_next  = (rem_next == 24'h0);
        end
      end
      default: state_next = cache_burst_pkg::ST_IDLE;
    endcase
    bus_req_next = (state_next == cache_burst_pkg::ST_REQ)
                 || (state_next == cache_burst_pkg::ST_XFER);
    busy_next    = bus_req_next | start_next;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg       <= cache_burst_pkg::ST_IDLE;
      burst_reg       <= '0;
      addr_reg        <= 32'h0;
      rem_reg         <= 24'h0;
      cnt_reg         <= 8'h00;
      lat_reg         <= 1'b0;
      misalign_reg    <= 1'b0;
      cls_reg         <= cache_burst_pkg::CLS_RESET;
      bus_req_reg     <= 1'b0;
      start_reg       <= 1'b0;
      done_reg        <= 1'b0;
      busy_reg        <= 1'b0;
      wdata_reg       <= 32'h0;
      job_write_reg   <= 1'b0;
      job_opfetch_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      burst_reg       <= burst_next;
      addr_reg        <= addr_next;
      rem_reg         <= rem_next;
      cnt_reg         <= cnt_next;
      lat_reg         <= lat_next;
      misalign_reg    <= misalign_next;
      cls_reg         <= cls_next;
      bus_req_reg     <= bus_req_next;
      start_reg       <= start_next;
      done_reg        <= done_next;
      busy_reg        <= busy_next;
      wdata_reg       <= fifo_data;
      job_write_reg   <= (state_reg == cache_burst_pkg::ST_IDLE) ? job_write_i : job_write_reg;
      job_opfetch_reg <= (state_reg == cache_burst_pkg::ST_IDLE) ? job_opfetch_i : job_opfetch_reg;
    end
  end

  cache_burst_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wdata_valid_i),
    .in_data_i   (wdata_i),
    .in_ready_o  (wdata_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  assign cfg_rdata_o   = cls_reg;
  assign job_busy_o    = busy_reg;
  assign job_done_o    = done_reg;
  assign bus_req_o     = bus_req_reg;
  assign burst_start_o = start_reg;
  assign burst_cmd_o   = burst_reg.cmd;
  assign burst_addr_o  = burst_reg.addr;
  assign burst_len_o   = burst_reg.len;
  assign byte_en_o     = burst_reg.be;
  assign pci_wdata_o   = wdata_reg;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic in_plan;
  assign in_plan = (state_reg == cache_burst_pkg::ST_PLAN);
  sequence seq_release_rearb;
    !bus_req_o ##1 bus_req_o;
  endsequence

  AST_EFF_LINE: assert property (eff_log <= max_log && (cls_log < 3'h1 || eff_log <= cls_log))
    else $error("effective line size too large");
  AST_QUAD_SINGLE: assert property (in_plan && cache_act && addr_reg[3:0] != 4'h0 && !line_al
    |=> burst_len_o == 8'h01)
    else $error("burst issued below quad boundary");
  AST_STEP_ALIGN: assert property (in_plan && cache_act && !line_al && plan.len > 8'h01
    |-> 32'(plan.len) < line_dw
    && (addr_reg & ((32'(plan.len) << 2) - 32'h1)) == 32'h0)
    else $error("burst not aligned to its size");
  AST_LINE_LEN: assert property (in_plan && cache_act && line_al && !mwi_ok && dw_left >= line_dw
    |=> 32'(burst_len_o) == line_dw)
    else $error("aligned burst not line sized");
  AST_MISALIGN: assert property (in_plan && misalign_reg |-> plan.cmd != cache_burst_pkg::CMD_WRITE_INV)
    else $error("write-invalidate during misaligned move");
  AST_MWI_GATE: assert property (in_plan ##1 burst_cmd_o == cache_burst_pkg::CMD_WRITE_INV
    |-> $past(line_al) && chip_test_reg_three_i[0] && pci_command_i[4])
    else $error("write-invalidate without its enables");
  AST_MWI_MULT: assert property (in_plan && plan.cmd == cache_burst_pkg::CMD_WRITE_INV
    |-> (32'(plan.len) & (line_dw - 32'h1)) == 32'h0 && 32'(plan.len) <= max_dw)
    else $error("write-invalidate length not a line multiple");
  AST_STOP_REARB: assert property (state_reg == cache_burst_pkg::ST_XFER && stop_s && rem_reg != 24'h0
    |=> seq_release_rearb)
    else $error("no release and re-arbitration after stop");
  AST_READ_LINE: assert property (in_plan && !job_write_reg && !job_opfetch_reg
    && dma_mode_reg_i[3] && !cache_mode_enable_i |=> burst_cmd_o == cache_burst_pkg::CMD_READ_LINE)
    else $error("read line not used");
  AST_RL_FALLBACK: assert property (in_plan && !job_write_reg && cache_mode_enable_i && !line_al
    |=> burst_cmd_o == cache_burst_pkg::CMD_MEM_READ)
    else $error("read fallback not plain read");
endmodule

// ===== verif/pci_target_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Arbiter and target stand-in
// ---------------------------------------------
module pci_target_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Master side
  input  wire logic       bus_req_i,
  input  wire logic       burst_start_i,
  input  wire logic [7:0] burst_len_i,
  // Scenario control, 8'hFF means never
  input  wire logic       slow_i,
  input  wire logic [7:0] stop_at_i,
  input  wire logic [7:0] lat_at_i,
  // Answers
  output logic            bus_gnt_o,
  output logic            target_ack_o,
  output logic            target_stop_o,
  output logic            lat_expired_o
);
  int left;
  int acks;
  int phase;
  int gwait;

  // Slow mode spaces data phases wider than the master's sync lag
  always @(negedge sys_clk_i) begin
    if (rst_i) begin
      bus_gnt_o     <= 1'b0;
      target_ack_o  <= 1'b0;
      target_stop_o <= 1'b0;
      lat_expired_o <= 1'b0;
      left = 0;
      acks = 0;
      phase = 0;
      gwait = 0;
    end else begin
      gwait = bus_req_i ? gwait + 1 : 0;
      bus_gnt_o     <= bus_req_i && (gwait > (slow_i ? 3 : 0));
      target_ack_o  <= 1'b0;
      target_stop_o <= 1'b0;
      if (burst_start_i) begin
        left = int'(burst_len_i);
        acks = 0;
        phase = 0;
      end
      if (!bus_req_i) begin
        left = 0;
        lat_expired_o <= 1'b0;
      end else if (left > 0) begin
        phase = slow_i ? (phase + 1) % 6 : 0;
        if (phase == 0 && acks == int'(stop_at_i)) begin
          target_stop_o <= 1'b1;
          left = 0;
        end else if (phase == 0) begin
          target_ack_o <= 1'b1;
          acks = acks + 1;
          left = left - 1;
          if (acks == int'(lat_at_i)) begin
            lat_expired_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ===== verif/tb_pci_cache_line_burst_control.sv
`timescale 1ns/10ps
module tb_pci_cache_line_burst_control;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  localparam logic [3:0] MR = cache_burst_pkg::CMD_MEM_READ;
  localparam logic [3:0] MW = cache_burst_pkg::CMD_MEM_WRITE;
  localparam logic [3:0] RL = cache_burst_pkg::CMD_READ_LINE;
  localparam logic [3:0] WI = cache_burst_pkg::CMD_WRITE_INV;
  logic        clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cme = 1'b0, wvalid = 1'b0, slow = 1'b0;
  logic        job_start = 1'b0, job_write = 1'b0, job_opf = 1'b0, job_move = 1'b0;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, dm = 8'h00, ct3 = 8'h00, ct5 = 8'h00;
  logic [7:0]  stop_at = 8'hFF, lat_at = 8'hFF;
  logic [15:0] pcmd = 16'h0000, fifo_bytes = 16'hFFFF;
  logic [31:0] job_addr = 32'h0, job_src = 32'h0, wdata = 32'h0;
  logic [23:0] job_bytes = 24'h0;
  logic        busy, done, wready, req, gnt, ack, stop, lat, bstart;
  logic [7:0]  cfg_rdata, blen;
  logic [3:0]  bcmd, be;
  logic [31:0] baddr, pwdata;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  cache_burst_pkg::burst_s got[$];

  always #12.5 clk = ~clk;

  cache_burst_ctrl u_dut (
    .sys_clk_i(clk), .rst_i(rst), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .dma_mode_reg_i(dm),
    .chip_test_reg_three_i(ct3), .chip_test_reg_five_i(ct5), .cache_mode_enable_i(cme),
    .pci_command_i(pcmd), .job_start_i(job_start), .job_addr_i(job_addr),
    .job_src_addr_i(job_src), .job_bytes_i(job_bytes), .job_write_i(job_write),
    .job_opfetch_i(job_opf), .job_mem_move_i(job_move), .dma_fifo_bytes_i(fifo_bytes),
    .job_busy_o(busy), .job_done_o(done), .wdata_valid_i(wvalid), .wdata_i(wdata),
    .wdata_ready_o(wready), .bus_req_o(req), .bus_gnt_i(gnt), .target_ack_i(ack),
    .target_stop_i(stop), .lat_expired_i(lat), .burst_start_o(bstart), .burst_cmd_o(bcmd),
    .burst_addr_o(baddr), .burst_len_o(blen), .byte_en_o(be), .pci_wdata_o(pwdata));

  pci_target_model u_far (
    .sys_clk_i(clk), .rst_i(rst), .bus_req_i(req), .burst_start_i(bstart),
    .burst_len_i(blen), .slow_i(slow), .stop_at_i(stop_at), .lat_at_i(lat_at),
    .bus_gnt_o(gnt), .target_ack_o(ack), .target_stop_o(stop), .lat_expired_o(lat));

  // ---------------------------------------------
  // Monitors
  // ---------------------------------------------
  // One stop and one expiry per arming, so a retry cannot loop forever
  always @(negedge clk) begin
    if (bstart === 1'b1) got.push_back({bcmd, baddr, blen, be});
    if (stop === 1'b1) stop_at = 8'hFF;
    if (lat === 1'b1) lat_at = 8'hFF;
  end
  always @(posedge clk) begin
    if (wvalid && wready) wdata <= wdata + 32'h1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      results();
    end
  end

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic bx(input int i, input logic [3:0] c, input logic [31:0] a, input logic [7:0] l);
    check(got.size() > i && got[i].cmd === c && (got[i].addr & ~32'h3) === a
          && got[i].len === l, $sformatf("burst %0d", i));
  endtask
  task automatic allcmd(input logic [3:0] c);
    check(got.size() > 0, "no burst");
    foreach (got[i]) check(got[i].cmd === c, $sformatf("command of burst %0d", i));
  endtask
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic mode(input logic [7:0] d, t3, t5, input logic c, input logic [15:0] p);
    dm = d;
    ct3 = t3;
    ct5 = t5;
    cme = c;
    pcmd = p;
  endtask
  task automatic job(input logic [31:0] a, s, input logic [23:0] n, input logic w, o, m);
    got.delete();
    job_addr = a;
    job_src = s;
    job_bytes = n;
    job_write = w;
    job_opf = o;
    job_move = m;
    job_start = 1'b1;
    @(negedge clk);
    job_start = 1'b0;
    @(negedge clk);
    check(busy === 1'b1, "busy not raised");
    repeat (4000) if (done !== 1'b1) @(negedge clk);
    check(done === 1'b1, "job never completed");
    @(negedge clk);
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check(cfg_rdata === cache_burst_pkg::CLS_RESET && req === 1'b0 && busy === 1'b0,
          "reset values");
    wvalid = 1'b1;
    repeat (12) @(negedge clk);
    check(wready === 1'b0 && wdata === 32'h8, "fifo should hold 8 words");
    cfg(8'h10, 8'h55);
    check(cfg_rdata === cache_burst_pkg::CLS_RESET, "unmapped write stored");
    cfg(cache_burst_pkg::CLS_OFFSET, 8'h10);
    check(cfg_rdata === 8'h10, "line size readback");
    $display("test registers finished");
    // Stepping alignment from a byte offset
    mode(8'hC0, 8'h00, 8'h00, 1'b1, 16'h0000);
    job(32'h1, 32'h0, 24'd127, 1'b1, 1'b0, 1'b0);
    bx(0, MW, 32'h00, 8'd1);
    check(got[0].be === 4'hE, "partial first dword lanes");
    bx(1, MW, 32'h04, 8'd1);
    bx(3, MW, 32'h0C, 8'd1);
    bx(4, MW, 32'h10, 8'd4);
    bx(5, MW, 32'h20, 8'd8);
    bx(6, MW, 32'h40, 8'd16);
    check(got.size() === 7, "burst count");
    check(pwdata === 32'h20, "write data after 32 dwords");
    // Line size rounding and max burst limit
    cfg(cache_burst_pkg::CLS_OFFSET, 8'h18);
    job(32'h0, 32'h0, 24'd128, 1'b0, 1'b0, 1'b0);
    bx(1, MR, 32'h40, 8'd16);
    dm = 8'h00;
    job(32'h0, 32'h0, 24'd32, 1'b0, 1'b0, 1'b0);
    bx(3, MR, 32'h18, 8'd2);
    $display("test alignment finished");
    // Write and invalidate
    cfg(cache_burst_pkg::CLS_OFFSET, 8'h04);
    mode(8'hC0, 8'h01, 8'h00, 1'b1, 16'h0010);
    job(32'h0, 32'h0, 24'd80, 1'b1, 1'b0, 1'b0);
    bx(0, WI, 32'h00, 8'd16);
    bx(1, WI, 32'h40, 8'd4);
    for (int k = 0; k < 3; k++) begin
      mode(8'hC0, k == 0 ? 8'h00 : 8'h01, 8'h00, k != 1, k == 2 ? 16'h0000 : 16'h0010);
      job(32'h0, 32'h0, 24'd32, 1'b1, 1'b0, 1'b0);
      check(got.size() > 0 && got[0].cmd === MW, "enable bit ignored");
    end
    mode(8'hC0, 8'h01, 8'h00, 1'b1, 16'h0010);
    fifo_bytes = 16'h000F;
    job(32'h0, 32'h0, 24'd32, 1'b1, 1'b0, 1'b0);
    allcmd(MW);
    fifo_bytes = 16'hFFFF;
    // Burst field 0 with the upper range bit gives 32 dwords
    mode(8'h00, 8'h01, 8'h04, 1'b1, 16'h0010);
    job(32'h0, 32'h0, 24'd256, 1'b1, 1'b0, 1'b0);
    bx(0, WI, 32'h00, 8'd32);
    // Retry, disconnect and latency expiry with a slow target
    mode(8'hC0, 8'h01, 8'h00, 1'b1, 16'h0010);
    slow = 1'b1;
    stop_at = 8'h00;
    job(32'h0, 32'h0, 24'd64, 1'b1, 1'b0, 1'b0);
    bx(1, WI, 32'h00, 8'd16);
    stop_at = 8'h02;
    job(32'h0, 32'h0, 24'd64, 1'b1, 1'b0, 1'b0);
    check(got[1].cmd === MW && got[1].addr[31:2] === 30'h2, "resume after disconnect");
    lat_at = 8'h05;
    job(32'h0, 32'h0, 24'd64, 1'b1, 1'b0, 1'b0);
    bx(1, WI, 32'h20, 8'd8);
    slow = 1'b0;
    $display("test write invalidate finished");
    // Read commands
    mode(8'hC8, 8'h00, 8'h00, 1'b0, 16'h0000);
    job(32'h4, 32'h0, 24'd24, 1'b0, 1'b0, 1'b0);
    allcmd(RL);
    job(32'h4, 32'h0, 24'd24, 1'b0, 1'b1, 1'b0);
    allcmd(MR);
    mode(8'h48, 8'h00, 8'h00, 1'b1, 16'h0000);
    job(32'h8, 32'h0, 24'd24, 1'b0, 1'b0, 1'b0);
    bx(1, MR, 32'h0C, 8'd1);
    bx(2, RL, 32'h10, 8'd4);
    dm = 8'hC8;
    job(32'h0, 32'h0, 24'd32, 1'b0, 1'b0, 1'b0);
    allcmd(MR);
    // Memory move offsets
    cfg(cache_burst_pkg::CLS_OFFSET, 8'h10);
    job(32'h4, 32'h0, 24'd60, 1'b0, 1'b0, 1'b1);
    check(got.size() > 0 && got[0].len !== 8'd1, "misaligned move aligned");
    job(32'h4, 32'h44, 24'd60, 1'b0, 1'b0, 1'b1);
    check(got.size() > 0 && got[0].len === 8'd1, "matched move not aligned");
    $display("test reads and moves finished");
    results();
  end
endmodule
